// *** verilog/baud_rate_generator.sv ***
// rate divider with register file on AHB-Lite and receive-pin majority sampling
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module baud_rate_generator (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        receive_pin,
    output logic             bit_tick,
    output logic             rx_bit_value,
    output logic             rx_bit_valid
);
    logic [7:0]  tx_ctrl_q;
    logic [7:0]  rx_ctrl_q;
    logic [7:0]  rate_ctrl_q;
    logic [7:0]  div_high_q;
    logic [7:0]  div_low_q;
    logic [15:0] div_count_q;
    logic [15:0] divisor;
    logic [2:0]  pre_log;
    logic        pre_tick;
    logic        div_write;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        rd_pend_q;
    logic [7:0]  rd_addr_q;
    logic        rate_tick;
    logic        sample_en;
    logic        bit_end;
    logic        rx_value;
    logic        rx_valid;
    logic        sync_mode;
    logic        wide_div;
    logic        high_speed;
    logic        port_en;
    logic [7:0]  rd_byte;
    logic        addr_ok;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase capture; NONSEQ and SEQ transfers of any size are decoded
    assign addr_ok = hsel && hready && (htrans == rate_gen_pkg::HTRANS_NONSEQ
                     || htrans == rate_gen_pkg::HTRANS_SEQ);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rd_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            rd_pend_q <= addr_ok && !hwrite;
            if (addr_ok) begin
                wr_addr_q <= haddr[7:0];
                rd_addr_q <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_high_q <= rate_gen_pkg::div_rst;
            div_low_q  <= rate_gen_pkg::div_rst;
        end else if (wr_pend_q) begin
            if (wr_addr_q == rate_gen_pkg::div_high_addr) begin
                div_high_q <= hwdata[7:0];
            end
            if (wr_addr_q == rate_gen_pkg::div_low_addr) begin
                div_low_q <= hwdata[7:0];
            end
        end
    end

    // read-only bits keep their reset value; status flags come from the divider count and the receive vote
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_ctrl_q   <= rate_gen_pkg::tx_ctrl_rst;
            rx_ctrl_q   <= rate_gen_pkg::rx_ctrl_rst;
            rate_ctrl_q <= rate_gen_pkg::rate_ctrl_rst;
        end else if (wr_pend_q) begin
            if (wr_addr_q == rate_gen_pkg::tx_ctrl_addr) begin
                tx_ctrl_q <= (hwdata[7:0] & rate_gen_pkg::tx_ctrl_mask)
                             | (tx_ctrl_q & ~rate_gen_pkg::tx_ctrl_mask);
            end
            if (wr_addr_q == rate_gen_pkg::rx_ctrl_addr) begin
                rx_ctrl_q <= (hwdata[7:0] & rate_gen_pkg::rx_ctrl_mask)
                             | (rx_ctrl_q & ~rate_gen_pkg::rx_ctrl_mask);
            end
            if (wr_addr_q == rate_gen_pkg::rate_ctrl_addr) begin
                rate_ctrl_q <= (hwdata[7:0] & rate_gen_pkg::rate_ctrl_mask)
                               | (rate_ctrl_q & ~rate_gen_pkg::rate_ctrl_mask);
            end
        end
    end

    assign sync_mode  = tx_ctrl_q[rate_gen_pkg::sync_bit];
    assign high_speed = tx_ctrl_q[rate_gen_pkg::high_speed_bit];
    assign wide_div   = rate_ctrl_q[rate_gen_pkg::wide_div_bit];
    assign port_en    = rx_ctrl_q[rate_gen_pkg::port_en_bit];

    assign divisor = wide_div ? {div_high_q, div_low_q} : {8'h00, div_low_q};

    always_comb begin
        if (sync_mode) begin
            pre_log = rate_gen_pkg::pre_4_log;
        end else if (!wide_div && !high_speed) begin
            pre_log = rate_gen_pkg::pre_64_log;
        end else if (wide_div && high_speed) begin
            pre_log = rate_gen_pkg::pre_4_log;
        end else begin
            pre_log = rate_gen_pkg::pre_16_log;
        end
    end

    assign div_write = wr_pend_q && (wr_addr_q == rate_gen_pkg::div_high_addr
                       || wr_addr_q == rate_gen_pkg::div_low_addr);

    prescale_counter u_prescale (
        .clk     (clk),
        .rst_b   (rst_b),
        .clear   (div_write || !port_en),
        .log_sel (pre_log),
        .tick    (pre_tick)
    );

    // down counter reloads with n, so n+1 prescale ticks per bit
    // a divisor write swallows a tick of the old rate in that same cycle
    assign rate_tick = pre_tick && (div_count_q == 16'h0000) && !div_write;

    always_ff @(posedge clk) begin
        if (!rst_b || div_write || !port_en) begin
            div_count_q <= 16'h0000;
        end else if (pre_tick) begin
            div_count_q <= (div_count_q == 16'h0000) ? divisor : div_count_q - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= rate_tick;
        end
    end

    // samples taken on prescale ticks in the middle of the bit
    assign sample_en = pre_tick && port_en && (div_count_q <= 16'(divisor >> 1))
                       && (div_count_q != 16'h0000);
    assign bit_end   = rate_tick;

    majority_sampler u_sampler (
        .clk         (clk),
        .rst_b       (rst_b),
        .sample_en   (sample_en),
        .bit_end     (bit_end),
        .receive_pin (receive_pin),
        .bit_value   (rx_value),
        .bit_valid   (rx_valid)
    );

    assign rx_bit_value = rx_value;
    assign rx_bit_valid = rx_valid;

    always_comb begin
        unique case (rd_addr_q)
            rate_gen_pkg::tx_ctrl_addr:   rd_byte = tx_ctrl_q;
            rate_gen_pkg::rx_ctrl_addr:   rd_byte = rx_ctrl_q;
            rate_gen_pkg::rate_ctrl_addr: rd_byte = rate_ctrl_q;
            rate_gen_pkg::div_high_addr:  rd_byte = div_high_q;
            rate_gen_pkg::div_low_addr:   rd_byte = div_low_q;
            rate_gen_pkg::status_addr:    rd_byte = {6'h00, rx_value, (div_count_q == 16'h0000)};
            default:                      rd_byte = 8'h00;
        endcase
    end

    assign hrdata = rd_pend_q ? {24'h000000, rd_byte} : 32'h00000000;
endmodule // baud_rate_generator
`default_nettype wire

// *** shared/rate_gen_pkg.sv ***
// register map, field positions, reset values and rate constants of the rate generator
package rate_gen_pkg;
    // byte addresses of the registers (word aligned)
    localparam logic [7:0] tx_ctrl_addr   = 8'h00;
    localparam logic [7:0] rx_ctrl_addr   = 8'h04;
    localparam logic [7:0] rate_ctrl_addr = 8'h08;
    localparam logic [7:0] div_high_addr  = 8'h0C;
    localparam logic [7:0] div_low_addr   = 8'h10;
    localparam logic [7:0] status_addr    = 8'h14;

    // field positions
    localparam int sync_bit       = 4;
    localparam int high_speed_bit = 2;
    localparam int wide_div_bit   = 3;
    localparam int port_en_bit    = 7;

    // writable masks of the control registers
    localparam logic [7:0] tx_ctrl_mask   = 8'hFD;
    localparam logic [7:0] rx_ctrl_mask   = 8'hF8;
    localparam logic [7:0] rate_ctrl_mask = 8'h1B;

    // reset values
    localparam logic [7:0] tx_ctrl_rst   = 8'h02;
    localparam logic [7:0] rx_ctrl_rst   = 8'h00;
    localparam logic [7:0] rate_ctrl_rst = 8'h40;
    localparam logic [7:0] div_rst       = 8'h00;

    // prescale factors, as log2 of the cycles per divider tick
    localparam logic [2:0] pre_64_log = 3'h6;
    localparam logic [2:0] pre_16_log = 3'h4;
    localparam logic [2:0] pre_4_log  = 3'h2;

    // receive samples per bit counted by the majority vote
    localparam int samples_per_bit = 3;

    typedef enum logic [1:0] {
        HTRANS_IDLE   = 2'h0,
        HTRANS_BUSY   = 2'h1,
        HTRANS_NONSEQ = 2'h2,
        HTRANS_SEQ    = 2'h3
    } htrans_t;
endpackage

// *** verilog/prescale_counter.sv ***
// prescaler: free-running counter giving one tick every 2**log_sel cycles for log_sel up to 6; log_sel 7 ticks every cycle
`timescale 1ns/100ps
`default_nettype none
module prescale_counter (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clear,
    input  wire logic [2:0] log_sel,
    output logic            tick
);
    logic [5:0] count_q;
    logic [5:0] last;

    assign last = 6'(({1'b0, 6'h3F} >> (3'h6 - log_sel)));
    assign tick = (count_q == last);

    always_ff @(posedge clk) begin
        if (!rst_b || clear || tick) begin
            count_q <= 6'h00;
        end else begin
            count_q <= count_q + 6'h01;
        end
    end
endmodule // prescale_counter
`default_nettype wire

// *** verilog/majority_sampler.sv ***
// three-sample majority vote on the receive pin
`timescale 1ns/100ps
`default_nettype none
module majority_sampler (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic sample_en,
    input  wire logic bit_end,
    input  wire logic receive_pin,
    output logic      bit_value,
    output logic      bit_valid
);
    logic [1:0] count_q;
    logic [1:0] ones_q;
    logic [1:0] ones_d;

    assign ones_d = ones_q + {1'b0, receive_pin};

    always_ff @(posedge clk) begin
        if (!rst_b || bit_end) begin
            count_q <= 2'h0;
            ones_q  <= 2'h0;
        end else if (sample_en && count_q != 2'h3) begin
            count_q <= count_q + 2'h1;
            ones_q  <= ones_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bit_value <= 1'b1;
            bit_valid <= 1'b0;
        end else begin
            bit_valid <= bit_end;
            if (bit_end) begin
                // majority of the samples counted; short bits may count fewer than three
                bit_value <= ({ones_q, 1'b0} > {1'b0, count_q});
            end
        end
    end
endmodule // majority_sampler
`default_nettype wire

// *** tb/baud_rate_generator_monitor.sv ***
// assertion checker on the rate generator ports
`timescale 1ns/100ps
`default_nettype none
module baud_rate_generator_monitor (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        bit_tick,
    input wire logic        rx_bit_value,
    input wire logic        rx_bit_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence rd_req;
        hsel && htrans[1] && !hwrite;
    endsequence
    sequence odd_rd;
        rd_req ##0 (haddr > {24'h0, rate_gen_pkg::status_addr});
    endsequence
    okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
    zero_wait_a: assert property (hreadyout == 1'b1) else $error("wait state seen");
    odd_read_a: assert property (odd_rd |=> hrdata == 32'h0) else $error("unmapped read not zero");
    idle_data_a: assert property (!(hsel && htrans[1] && !hwrite) |=> hrdata == 32'h0) else $error("data outside read");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
    vote_tick_a: assert property (rx_bit_valid == bit_tick) else $error("vote not at bit end");
    valid_pulse_a: assert property (rx_bit_valid |=> !rx_bit_valid) else $error("vote pulse too long");
    value_hold_a: assert property (!rx_bit_valid |-> $stable(rx_bit_value)) else $error("vote moved");
endmodule // baud_rate_generator_monitor
bind baud_rate_generator baud_rate_generator_monitor u_mon (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hrdata, .hreadyout, .hresp, .bit_tick, .rx_bit_value, .rx_bit_valid);
`default_nettype wire

// *** tb/remote_line_model.sv ***
// remote transceiver driving the receive line
`timescale 1ns/100ps
`default_nettype none
module remote_line_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic bit_tick,
    input  wire logic next_level,
    output logic      receive_pin
);
    // idle is mark; level moves only at bit ends so no bit is split
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            receive_pin <= 1'b1;
        end else if (bit_tick) begin
            receive_pin <= next_level;
        end
    end
endmodule // remote_line_model
`default_nettype wire

// *** tb/baud_rate_generator_tb.sv ***
// self-checking bench: registers, rate per mode, receive vote
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("wrong value at %0t: %h", $time, g); end end
module baud_rate_generator_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        receive_pin;
    logic        next_level = 1'b1;
    logic        bit_tick;
    logic        rx_bit_value;
    logic        rx_bit_valid;
    logic        rx_chk = 1'b0;
    logic [31:0] rd;
    int          errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          gap = 0;
    int          expv;
    int          exp_q[$];
    logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    logic [7:0]  rv [6] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    logic [7:0]  rw [6] = '{8'hFF, 8'hF8, 8'h5B, 8'hFF, 8'hFF, 8'h00};
    always #5 clk = ~clk;
    baud_rate_generator u_dut (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .receive_pin(receive_pin), .bit_tick(bit_tick), .rx_bit_value(rx_bit_value),
        .rx_bit_valid(rx_bit_valid)
    );
    remote_line_model u_line (.clk(clk), .rst_b(rst_b), .bit_tick(bit_tick), .next_level(next_level),
        .receive_pin(receive_pin));
    task automatic report_and_stop();
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= rate_gen_pkg::HTRANS_NONSEQ;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= rate_gen_pkg::HTRANS_IDLE;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        d = hrdata;
    endtask
    task automatic wait_tick(input int lim);
        int k;
        k = 0;
        @(posedge clk);
        while (bit_tick !== 1'b1) begin
            k++;
            if (k > lim) begin
                errors++;
                break;
            end
            @(posedge clk);
        end
    endtask
    task automatic run_mode(input logic [2:0] m);
        logic [7:0] lo;
        int         p;
        lo = 8'($urandom_range(7, 3));
        // high byte nonzero so narrow modes show it is ignored
        p = (m[1] ? 256 + lo : lo) + 1;
        p = p * (m[2] ? 4 : (m[1] ? (m[0] ? 4 : 16) : (m[0] ? 16 : 64)));
        rx_chk = 1'b0;
        bus(rate_gen_pkg::tx_ctrl_addr, 1'b1, {27'h0, m[2], 1'b0, m[0], 2'h0}, rd);
        bus(rate_gen_pkg::rate_ctrl_addr, 1'b1, {28'h0, m[1], 3'h0}, rd);
        bus(rate_gen_pkg::div_high_addr, 1'b1, 32'h1, rd);
        bus(rate_gen_pkg::div_low_addr, 1'b1, {24'h0, lo}, rd);
        // old count must not delay the first tick
        wait_tick(p + 4);
        exp_q.push_back(p);
        rx_chk = 1'b1;
        wait_tick(p + 4);
        wait_tick(p + 4);
    endtask
    always @(posedge clk) next_level <= 1'($urandom);
    always @(negedge clk) begin
        cycles++;
        if (cycles > 80000) begin
            errors++;
            report_and_stop();
        end
        if (rx_chk && rx_bit_valid === 1'b1) `CHK(rx_bit_value, receive_pin)
        if (bit_tick === 1'b1) begin
            if (exp_q.size() > 0) begin
                expv = exp_q.pop_front();
                `CHK(gap, expv)
            end
            gap = 1;
        end else begin
            gap++;
        end
    end
    initial begin
        void'($urandom(90));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(ra[i], 1'b0, 32'h0, rd);
            `CHK(rd, {24'h0, rv[i]})
        end
        for (int i = 0; i < 6; i++) bus(ra[i], 1'b1, 32'hFFFFFFFF, rd);
        for (int i = 0; i < 6; i++) begin
            bus(ra[i], 1'b0, 32'h0, rd);
            `CHK(rd, {24'h0, rw[i]})
        end
        for (int m = 0; m < 8; m++) run_mode(3'(m));
        report_and_stop();
    end
endmodule // baud_rate_generator_tb
`default_nettype wire
